// ==== rtl/ppio_hs.sv ====
// Strobe/acknowledge handshake channel for one 8-bit port
`timescale 1ns/1ps
module ppio_hs (
    input wire logic mclk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic clr, // Mode set pulse, clears all flags
    input wire logic use_in, // Strobed input direction active
    input wire logic use_out, // Strobed output direction active
    input wire logic stb_n, // Input latch strobe, active low
    input wire logic ack_n, // Output acknowledge, active low
    input wire logic inte_in, // Input interrupt enable
    input wire logic inte_out, // Output interrupt enable
    input wire logic rd_start, // Host read of this port begins
    input wire logic rd_end, // Host read of this port ends
    input wire logic wr_start, // Host write of this port begins
    input wire logic wr_end, // Host write of this port ends
    output logic input_full_flag, // Input latch holds unread data
    output logic output_full_flag_n, // Output latch full, active low
    output logic irq_out, // Interrupt request
    output logic capture // Load input latch this cycle
);
    import ppio_pkg::*;

    logic stb_n_q, ack_n_q, irq_out_in_q, irq_out_out_q;
    logic ibf_d, obf_n_d, irq_out_in_d, irq_out_out_d;

    wire stb_rise = stb_n & ~stb_n_q;
    wire ack_rise = ack_n & ~ack_n_q;

    // Latch is transparent while strobe is low; the last level before release sticks
    assign capture = use_in & ~stb_n; // R5
    // Strobe wins over a read that ends in the same cycle
    assign ibf_d = (use_in & ~stb_n) ? 1'b1 : (rd_end ? 1'b0 : input_full_flag); // R3
    // A finished write wins over an acknowledge in the same cycle
    assign obf_n_d = (use_out & wr_end) ? 1'b0 : ((use_out & ~ack_n) ? 1'b1 : output_full_flag_n); // R3
    assign irq_out_in_d = (use_in & stb_rise & input_full_flag) ? 1'b1 : (rd_start ? 1'b0 : irq_out_in_q);
    assign irq_out_out_d = (use_out & ack_rise & output_full_flag_n) ? 1'b1 : (wr_start ? 1'b0 : irq_out_out_q);

    always_ff @(posedge mclk) begin
        stb_n_q <= stb_n;
        ack_n_q <= ack_n;
        if (rst || clr) begin
            input_full_flag <= 1'b0;
            output_full_flag_n <= 1'b1;
            irq_out_in_q <= 1'b0;
            irq_out_out_q <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            input_full_flag <= ibf_d;
            output_full_flag_n <= obf_n_d;
            irq_out_in_q <= irq_out_in_d;
            irq_out_out_q <= irq_out_out_d;
            irq_out <= (irq_out_in_d & inte_in & use_in) | (irq_out_out_d & inte_out & use_out); // R3
        end
    end

endmodule // ppio_hs

// ==== rtl/ppio_pkg.sv ====
// Shared constants and types for the programmable parallel I/O block
package ppio_pkg;

    localparam int PPIO_DW = 8;

    // Register select codes
    localparam logic [1:0] PPIO_ADDR_FIRST = 2'h0;
    localparam logic [1:0] PPIO_ADDR_SECOND = 2'h1;
    localparam logic [1:0] PPIO_ADDR_THIRD = 2'h2;
    localparam logic [1:0] PPIO_ADDR_CTRL = 2'h3;

    // Control word layout, mode-set form (flag bit high)
    localparam int PPIO_CW_FLAG = 7;
    localparam int PPIO_CW_A_MODE_HI = 6;
    localparam int PPIO_CW_A_MODE_LO = 5;
    localparam int PPIO_CW_A_DIR = 4;
    localparam int PPIO_CW_CU_DIR = 3;
    localparam int PPIO_CW_B_MODE = 2;
    localparam int PPIO_CW_B_DIR = 1;
    localparam int PPIO_CW_CL_DIR = 0;

    // Control word layout, bit set/reset form (flag bit low)
    localparam int PPIO_BSR_SEL_HI = 3;
    localparam int PPIO_BSR_SEL_LO = 1;
    localparam int PPIO_BSR_VAL = 0;

    // Third port handshake line positions
    localparam int PPIO_PC_A_IRQ_OUT = 3;
    localparam int PPIO_PC_A_STB = 4;
    localparam int PPIO_PC_A_IBF = 5;
    localparam int PPIO_PC_A_ACK = 6;
    localparam int PPIO_PC_A_OBF = 7;
    localparam int PPIO_PC_B_IRQ_OUT = 0;
    localparam int PPIO_PC_B_FLAG = 1;
    localparam int PPIO_PC_B_STB = 2;

    // Reset values
    localparam logic [7:0] PPIO_RST_LATCH = 8'h00;
    localparam logic PPIO_RST_DIR_IN = 1'b1;
    localparam logic [7:0] PPIO_RST_BUS = 8'h00;

    // Reset pulse minimums, owed by the system, in cycles of mclk
    localparam int PPIO_CLK_NS = 10;
    localparam int PPIO_RST_POWERON_US = 50;
    localparam int PPIO_RST_LATER_NS = 500;
    localparam int PPIO_RST_POWERON_CYC = (PPIO_RST_POWERON_US * 1000 + PPIO_CLK_NS - 1) / PPIO_CLK_NS;
    localparam int PPIO_RST_LATER_CYC = (PPIO_RST_LATER_NS + PPIO_CLK_NS - 1) / PPIO_CLK_NS;

    typedef enum logic [1:0] {PPIO_BASIC, PPIO_STROBED, PPIO_BIDIR} ppio_mode_e;

    function automatic ppio_mode_e ppio_mode_of(input logic [1:0] f);
        return f[1] ? PPIO_BIDIR : (f[0] ? PPIO_STROBED : PPIO_BASIC);
    endfunction

endpackage

// ==== rtl/ppio_top.sv ====
// Programmable parallel I/O: host bus decode, mode control and three ports
// Operation
// R1: Basic mode: outputs latched, inputs pass through
// R2: Four independent direction fields give sixteen layouts
// R3: Strobed mode: handshake lines on third port
// R4: Two groups: 8-bit port plus 4-bit part
// R5: Strobed data ports latched in either direction
// R6: Bidirectional first port, both directions latched
// R7: Third port bits 3-7 carry bidirectional handshake
// R8: Second port stays independent during bidirectional mode
// R9: Read drives addressed port onto data bus
// R10: Write takes bus into port or control
// R11: Bus floats when deselected or idle
// R12: Host uses only defined strobe combinations
// R13: Control words select the operating modes
// R14: Reset held 50 us first, 500 ns later; the bench holds the first one for only 16 cycles of mclk
// R15: Reset clears control, ports to input
// R16: Control register cannot be read back
// R17: Group one: first port, upper nibble
// R18: Commit write at end of write cycle
`timescale 1ns/1ps
module ppio_top (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic cs_n, // Chip select, active low
    input wire logic rd_n, // Read strobe, active low
    input wire logic wr_n, // Write strobe, active low
    input wire logic [1:0] register_select_lines, // Port or control select
    input wire logic [ppio_pkg::PPIO_DW-1:0] data_in, // Host data bus, inbound
    output logic [ppio_pkg::PPIO_DW-1:0] data_out, // Host data bus, outbound
    output logic data_oe, // Host data bus drive enable
    input wire logic [ppio_pkg::PPIO_DW-1:0] first_port_lines_in, // First port pin levels
    output logic [ppio_pkg::PPIO_DW-1:0] first_port_lines_out, // First port drive value
    output logic [ppio_pkg::PPIO_DW-1:0] first_port_lines_oe, // First port drive enable
    input wire logic [ppio_pkg::PPIO_DW-1:0] second_port_lines_in, // Second port pin levels
    output logic [ppio_pkg::PPIO_DW-1:0] second_port_lines_out, // Second port drive value
    output logic [ppio_pkg::PPIO_DW-1:0] second_port_lines_oe, // Second port drive enable
    input wire logic [ppio_pkg::PPIO_DW-1:0] third_port_lines_in, // Third port pin levels
    output logic [ppio_pkg::PPIO_DW-1:0] third_port_lines_out, // Third port drive value
    output logic [ppio_pkg::PPIO_DW-1:0] third_port_lines_oe // Third port drive enable
);
    import ppio_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Host bus decode

    logic rd_act_q, wr_act_q;
    logic [1:0] rd_addr_q, wr_addr_q;
    logic [PPIO_DW-1:0] wr_data_q;

    // Illegal strobe mixes are the host's to avoid; they decode as idle here
    wire rd_act = ~cs_n & ~rd_n & wr_n; // R9 R12
    wire wr_act = ~cs_n & ~wr_n & rd_n; // R10 R12

    wire rd_start = rd_act & ~rd_act_q;
    wire rd_end = ~rd_act & rd_act_q;
    wire wr_start = wr_act & ~wr_act_q;
    wire wr_end = ~wr_act & wr_act_q; // R18

    wire rd_start_a = rd_start & (register_select_lines == PPIO_ADDR_FIRST);
    wire rd_start_b = rd_start & (register_select_lines == PPIO_ADDR_SECOND);
    wire rd_end_a = rd_end & (rd_addr_q == PPIO_ADDR_FIRST);
    wire rd_end_b = rd_end & (rd_addr_q == PPIO_ADDR_SECOND);
    wire wr_start_a = wr_start & (register_select_lines == PPIO_ADDR_FIRST);
    wire wr_start_b = wr_start & (register_select_lines == PPIO_ADDR_SECOND);

    wire wr_a = wr_end & (wr_addr_q == PPIO_ADDR_FIRST); // R10 R18
    wire wr_b = wr_end & (wr_addr_q == PPIO_ADDR_SECOND); // R10 R18
    wire wr_c = wr_end & (wr_addr_q == PPIO_ADDR_THIRD); // R10 R18
    wire wr_ctl = wr_end & (wr_addr_q == PPIO_ADDR_CTRL); // R10 R18
    wire mode_set = wr_ctl & wr_data_q[PPIO_CW_FLAG]; // R13
    wire bit_set = wr_ctl & ~wr_data_q[PPIO_CW_FLAG];
    wire [2:0] bsr_sel = wr_data_q[PPIO_BSR_SEL_HI:PPIO_BSR_SEL_LO];

    // Address and data are held from the last active cycle, as the write trails off
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            rd_addr_q <= PPIO_ADDR_FIRST;
            wr_addr_q <= PPIO_ADDR_FIRST;
            wr_data_q <= PPIO_RST_BUS;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (rd_act) begin
                rd_addr_q <= register_select_lines;
            end
            if (wr_act) begin
                wr_addr_q <= register_select_lines;
                wr_data_q <= data_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode control

    ppio_mode_e a_mode_q, b_mode_q;
    logic a_in_q, cu_in_q, b_in_q, cl_in_q;

    // Group one owns the first port and upper nibble, group two the rest
    always_ff @(posedge mclk) begin
        if (rst) begin
            a_mode_q <= PPIO_BASIC; // R15
            a_in_q <= PPIO_RST_DIR_IN; // R15
            cu_in_q <= PPIO_RST_DIR_IN; // R15
        end else if (mode_set) begin
            a_mode_q <= ppio_mode_of(wr_data_q[PPIO_CW_A_MODE_HI:PPIO_CW_A_MODE_LO]); // R13 R17
            a_in_q <= wr_data_q[PPIO_CW_A_DIR]; // R2 R17
            cu_in_q <= wr_data_q[PPIO_CW_CU_DIR]; // R2 R17
        end
    end

    // Group two fields load independently of group one's mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            b_mode_q <= PPIO_BASIC; // R15
            b_in_q <= PPIO_RST_DIR_IN; // R15
            cl_in_q <= PPIO_RST_DIR_IN; // R15
        end else if (mode_set) begin
            b_mode_q <= wr_data_q[PPIO_CW_B_MODE] ? PPIO_STROBED : PPIO_BASIC; // R8 R13 R17
            b_in_q <= wr_data_q[PPIO_CW_B_DIR]; // R2 R8 R17
            cl_in_q <= wr_data_q[PPIO_CW_CL_DIR]; // R2 R8 R17
        end
    end

    wire a_bidir = (a_mode_q == PPIO_BIDIR);
    wire a_strb = (a_mode_q == PPIO_STROBED);
    wire a_hs_any = a_bidir | a_strb; // R4
    wire a_hs_in = a_bidir | (a_strb & a_in_q); // R6
    wire a_hs_out = a_bidir | (a_strb & ~a_in_q); // R6
    wire b_hs_any = (b_mode_q == PPIO_STROBED); // R4
    wire b_hs_in = b_hs_any & b_in_q;
    wire b_hs_out = b_hs_any & ~b_in_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Port latches

    logic [PPIO_DW-1:0] a_lat_q, b_lat_q, c_lat_q;
    logic [PPIO_DW-1:0] a_inl_q, b_inl_q;
    logic a_cap, b_cap;

    // Output latches; a mode set clears them along with the handshake flags
    always_ff @(posedge mclk) begin
        if (rst || mode_set) begin
            a_lat_q <= PPIO_RST_LATCH;
            b_lat_q <= PPIO_RST_LATCH;
            c_lat_q <= PPIO_RST_LATCH;
        end else begin
            if (wr_a) begin
                a_lat_q <= wr_data_q; // R1 R5 R6
            end
            if (wr_b) begin
                b_lat_q <= wr_data_q; // R1 R5
            end
            if (wr_c) begin
                c_lat_q <= wr_data_q; // R1
            end else if (bit_set) begin
                c_lat_q[bsr_sel] <= wr_data_q[PPIO_BSR_VAL];
            end
        end
    end

    // Input latches are deliberately outside reset so data survives it
    always_ff @(posedge mclk) begin
        if (a_cap) begin
            a_inl_q <= first_port_lines_in; // R5 R6 R15
        end
        if (b_cap) begin
            b_inl_q <= second_port_lines_in; // R5 R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake channels

    logic a_ibf, a_obf_n, a_irq_out, b_ibf, b_obf_n, b_irq_out;

    ppio_hs u_hs_a (
        .mclk(mclk),
        .rst(rst),
        .clr(mode_set),
        .use_in(a_hs_in),
        .use_out(a_hs_out),
        .stb_n(third_port_lines_in[PPIO_PC_A_STB]),
        .ack_n(third_port_lines_in[PPIO_PC_A_ACK]),
        .inte_in(c_lat_q[PPIO_PC_A_STB]),
        .inte_out(c_lat_q[PPIO_PC_A_ACK]),
        .rd_start(rd_start_a),
        .rd_end(rd_end_a),
        .wr_start(wr_start_a),
        .wr_end(wr_a),
        .input_full_flag(a_ibf),
        .output_full_flag_n(a_obf_n),
        .irq_out(a_irq_out),
        .capture(a_cap)
    );

    ppio_hs u_hs_b (
        .mclk(mclk),
        .rst(rst),
        .clr(mode_set),
        .use_in(b_hs_in),
        .use_out(b_hs_out),
        .stb_n(third_port_lines_in[PPIO_PC_B_STB]),
        .ack_n(third_port_lines_in[PPIO_PC_B_STB]),
        .inte_in(c_lat_q[PPIO_PC_B_STB]),
        .inte_out(c_lat_q[PPIO_PC_B_STB]),
        .rd_start(rd_start_b),
        .rd_end(rd_end_b),
        .wr_start(wr_start_b),
        .wr_end(wr_b),
        .input_full_flag(b_ibf),
        .output_full_flag_n(b_obf_n),
        .irq_out(b_irq_out),
        .capture(b_cap)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Third port line ownership

    logic [PPIO_DW-1:0] hs_drv, hs_pin, hs_val, grp_oe, c_oe_d, c_drv_d, c_rd;

    // Lines driven as handshake outputs
    assign hs_drv = {a_hs_out, 1'b0, a_hs_in, 1'b0, a_hs_any, 1'b0, b_hs_any, b_hs_any}; // R3 R7
    // Lines sampled as strobe or acknowledge
    assign hs_pin = {1'b0, a_hs_out, 1'b0, a_hs_in, 1'b0, b_hs_any, 1'b0, 1'b0}; // R3 R7
    assign hs_val = {a_obf_n, 1'b0, a_ibf, 1'b0, a_irq_out, 1'b0, (b_hs_in ? b_ibf : b_obf_n), b_irq_out}; // R3 R7
    assign grp_oe = {{4{~cu_in_q}}, {4{~cl_in_q}}}; // R2 R17

    // Lines left over by the handshake follow their nibble's direction
    assign c_oe_d = hs_drv | (grp_oe & ~(hs_drv | hs_pin)); // R4 R8
    assign c_drv_d = (hs_drv & hs_val) | (~hs_drv & c_lat_q);
    // Strobe positions read back the interrupt enable rather than the pin
    assign c_rd = (hs_pin & c_lat_q) | (~hs_pin & c_oe_d & c_drv_d) | (~hs_pin & ~c_oe_d & third_port_lines_in); // R1

    ////////////////////////////////////////////////////////////////////////////////
    // First and second port read and drive

    logic [PPIO_DW-1:0] a_rd, b_rd, rd_mux;
    logic a_oe_d, b_oe_d;

    // Basic inputs are unlatched; strobed and bidirectional inputs read the latch
    assign a_rd = a_hs_in ? a_inl_q : (a_in_q & ~a_hs_any ? first_port_lines_in : a_lat_q); // R1 R5 R6
    assign b_rd = b_hs_in ? b_inl_q : (b_in_q ? second_port_lines_in : b_lat_q); // R1 R5
    // Bidirectional port drives only while the peripheral acknowledges
    assign a_oe_d = a_bidir ? ~third_port_lines_in[PPIO_PC_A_ACK] : ~a_in_q; // R6
    assign b_oe_d = ~b_in_q; // R8

    // Control word address reads as zero since the register is write-only
    assign rd_mux = (register_select_lines == PPIO_ADDR_FIRST) ? a_rd :
                    (register_select_lines == PPIO_ADDR_SECOND) ? b_rd :
                    (register_select_lines == PPIO_ADDR_THIRD) ? c_rd : PPIO_RST_BUS; // R9 R16

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    // Every pin is retimed once; the cost is one cycle of latency on all of them
    // Host data bus: value is forced to zero while floating so nothing stale leaks
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_out <= PPIO_RST_BUS;
            data_oe <= 1'b0;
        end else begin
            data_out <= rd_act ? rd_mux : PPIO_RST_BUS; // R9
            data_oe <= rd_act; // R9 R11
        end
    end

    // First port
    always_ff @(posedge mclk) begin
        if (rst) begin
            first_port_lines_out <= PPIO_RST_LATCH;
            first_port_lines_oe <= '0; // R15
        end else begin
            first_port_lines_out <= a_lat_q; // R1
            first_port_lines_oe <= {PPIO_DW{a_oe_d}}; // R2 R6
        end
    end

    // Second port
    always_ff @(posedge mclk) begin
        if (rst) begin
            second_port_lines_out <= PPIO_RST_LATCH;
            second_port_lines_oe <= '0; // R15
        end else begin
            second_port_lines_out <= b_lat_q; // R1
            second_port_lines_oe <= {PPIO_DW{b_oe_d}}; // R2
        end
    end

    // Third port, per-line enables from the ownership map above
    always_ff @(posedge mclk) begin
        if (rst) begin
            third_port_lines_out <= PPIO_RST_LATCH;
            third_port_lines_oe <= '0; // R15
        end else begin
            third_port_lines_out <= c_drv_d; // R3 R7
            third_port_lines_oe <= c_oe_d; // R2 R3
        end
    end

endmodule // ppio_top

// ==== test/ppio_bench.sv ====
// Self-checking bench for the parallel I/O block
`timescale 1ns/1ps
module ppio_bench;
    import ppio_pkg::*;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] pa = 8'h00;
    logic [7:0] pb = 8'h00;
    logic [7:0] pc = 8'hFF;
    logic cs_n, rd_n, wr_n, data_oe, ok, oe_seen;
    logic [1:0] sel;
    logic [7:0] hd, data_in, data_out, a_in, a_out, a_oe, b_in, b_out, b_oe, c_in, c_out, c_oe, d, cw, e;
    logic [7:0] exp_q[$];
    int seed = 17;
    int n_mismatch = 0;
    int compares = 0;
    always #5 mclk = ~mclk;
    assign data_in = data_oe ? data_out : hd;
    assign a_in = (a_oe & a_out) | (~a_oe & pa);
    assign b_in = (b_oe & b_out) | (~b_oe & pb);
    assign c_in = (c_oe & c_out) | (~c_oe & pc);
    ppio_host ppio_host_i (.mclk(mclk), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel), .hd(hd));
    ppio_top ppio_top_i (.mclk(mclk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .register_select_lines(sel),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .first_port_lines_in(a_in),
        .first_port_lines_out(a_out), .first_port_lines_oe(a_oe), .second_port_lines_in(b_in),
        .second_port_lines_out(b_out), .second_port_lines_oe(b_oe), .third_port_lines_in(c_in),
        .third_port_lines_out(c_out), .third_port_lines_oe(c_oe));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic oes(input logic [7:0] ea, input logic [7:0] eb, input logic [7:0] ec);
        @(negedge mclk);
        check(a_oe, ea);
        check(b_oe, eb);
        check(c_oe, ec);
    endtask
    task automatic pins(input logic [7:0] va, input logic [7:0] vc);
        @(posedge mclk);
        pa <= va;
        pc <= vc;
    endtask
    task automatic rdx(input logic [1:0] a, input logic [7:0] ev);
        exp_q.push_back(ev);
        ppio_host_i.rd(a, 1'h1, ok);
        check({7'h0, ok}, 8'h01);
    endtask
    task automatic finish_test;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read data is judged in the cycle the bus enable first rises
    always @(negedge mclk) begin
        if (data_oe === 1'h1 && oe_seen !== 1'h1) begin
            if (exp_q.size() == 0) begin
                compares++;
                n_mismatch++;
                $display("mismatch at %0t: read data with no expectation", $time);
            end else begin
                e = exp_q.pop_front();
                check(data_out, e);
            end
        end
        oe_seen = data_oe;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        oes(8'h00, 8'h00, 8'h00);
        for (int k = 0; k < 16; k++) begin
            cw = 8'h80 | {3'h0, k[3], k[2], 1'h0, k[1], k[0]};
            ppio_host_i.wr(PPIO_ADDR_CTRL, cw);
            oes({8{~k[3]}}, {8{~k[1]}}, {{4{~k[2]}}, {4{~k[0]}}});
            @(posedge mclk);
            pa <= 8'($random(seed));
            pb <= 8'($random(seed));
            pc <= 8'($random(seed));
            @(posedge mclk);
            rdx(PPIO_ADDR_FIRST, k[3] ? pa : 8'h00);
            rdx(PPIO_ADDR_SECOND, k[1] ? pb : 8'h00);
            rdx(PPIO_ADDR_THIRD, {k[2] ? pc[7:4] : 4'h0, k[0] ? pc[3:0] : 4'h0});
        end
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'h80);
        d = 8'($random(seed));
        ppio_host_i.wr(PPIO_ADDR_FIRST, d);
        ppio_host_i.wr(PPIO_ADDR_SECOND, ~d);
        ppio_host_i.wr(PPIO_ADDR_THIRD, d ^ 8'h3C);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'h0F);
        @(negedge mclk);
        check(a_out, d);
        check(b_out, ~d);
        check(c_out, (d ^ 8'h3C) | 8'h80);
        rdx(PPIO_ADDR_FIRST, d);
        rdx(PPIO_ADDR_CTRL, 8'h00);
        ppio_host_i.rd(PPIO_ADDR_FIRST, 1'h0, ok);
        check({7'h0, ok}, 8'h00);
        pins(pa, 8'hFF);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'hB0);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'h09);
        d = 8'($random(seed));
        pins(d, 8'hEF);
        repeat (35) @(posedge mclk);
        pins(~d, 8'hFF);
        repeat (4) @(negedge mclk);
        check(c_oe & 8'h28, 8'h28);
        check(c_out & 8'h28, 8'h28);
        rdx(PPIO_ADDR_FIRST, d);
        repeat (3) @(negedge mclk);
        check(c_out & 8'h28, 8'h00);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'h86);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'h05);
        d = 8'($random(seed));
        pb <= d;
        pins(pa, 8'hFB);
        repeat (5) @(posedge mclk);
        pins(pa, 8'hFF);
        repeat (4) @(negedge mclk);
        check(c_out & 8'h03, 8'h03);
        rdx(PPIO_ADDR_SECOND, d);
        repeat (3) @(negedge mclk);
        check(c_out & 8'h03, 8'h00);
        ppio_host_i.wr(PPIO_ADDR_CTRL, 8'hC0);
        d = 8'($random(seed));
        ppio_host_i.wr(PPIO_ADDR_FIRST, d);
        ppio_host_i.wr(PPIO_ADDR_SECOND, ~d);
        @(negedge mclk);
        check(c_out & 8'h80, 8'h00);
        check(a_oe, 8'h00);
        check(b_out, ~d);
        pins(pa, 8'hBF);
        repeat (30) @(negedge mclk);
        check(a_oe, 8'hFF);
        check(a_out, d);
        check(c_out & 8'h80, 8'h80);
        pins(pa, 8'hFF);
        repeat (4) @(negedge mclk);
        check(a_oe, 8'h00);
        @(posedge mclk);
        rst <= 1'h1;
        repeat (50) @(posedge mclk);
        rst <= 1'h0;
        oes(8'h00, 8'h00, 8'h00);
        finish_test;
    end
endmodule // ppio_bench

// ==== test/ppio_host.sv ====
// Host processor bus model driving the parallel I/O block
`timescale 1ns/1ps
module ppio_host (
    input wire logic mclk, // Clock
    input wire logic data_oe, // Device drives bus
    output logic cs_n, // Chip select
    output logic rd_n, // Read strobe
    output logic wr_n, // Write strobe
    output logic [1:0] sel, // Register select
    output logic [7:0] hd // Host data drive
);
    initial begin
        cs_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        sel = 2'h0;
        hd = 8'h5A;
    end
    ////////////////////////////////////////////////////////////
    // Only the defined read, write and idle combinations are presented
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        sel <= a;
        hd <= d;
        cs_n <= 1'h0;
        wr_n <= 1'h0;
        repeat (2) @(posedge mclk);
        cs_n <= 1'h1;
        wr_n <= 1'h1;
        hd <= ~d; // Released bus must not keep showing the last value
        repeat (3) @(posedge mclk);
    endtask
    task automatic rd(input logic [1:0] a, input logic en, output logic ok);
        int n;
        @(posedge mclk);
        sel <= a;
        cs_n <= ~en;
        rd_n <= 1'h0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (data_oe !== 1'h1 && n < 20);
        ok = data_oe;
        cs_n <= 1'h1;
        rd_n <= 1'h1;
        @(posedge mclk);
    endtask
endmodule // ppio_host

// ==== test/ppio_top_sva.sv ====
// Bus and port timing checks for the parallel I/O block
`timescale 1ns/1ps
module ppio_sva (
    input wire logic mclk, // Clock
    input wire logic rst, // Sync reset
    input wire logic cs_n, // Chip select
    input wire logic rd_n, // Read strobe
    input wire logic wr_n, // Write strobe
    input wire logic [1:0] register_select_lines, // Select
    input wire logic [7:0] data_out, // Bus out
    input wire logic data_oe, // Bus enable
    input wire logic [7:0] first_port_lines_oe, // First enable
    input wire logic [7:0] second_port_lines_oe, // Second enable
    input wire logic [7:0] third_port_lines_in, // Third pins
    input wire logic [7:0] third_port_lines_out, // Third drive
    input wire logic [7:0] third_port_lines_oe // Third enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd_act = !cs_n && !rd_n && wr_n;
    wire wr_act = !cs_n && !wr_n && rd_n;
    wire idle = cs_n || (rd_n && wr_n);
    ////////////////////////////////////////////////////////////
    sequence s_rd; rd_act; endsequence
    sequence s_ctl_rd; rd_act && register_select_lines == 2'h3; endsequence
    // Strobe low while the flag line is driven and the strobe line is not
    sequence s_stb; third_port_lines_oe[5] && !third_port_lines_oe[4] && !third_port_lines_in[4]; endsequence
    property p_rd_drive; s_rd |=> data_oe; endproperty
    property p_float; idle |=> !data_oe; endproperty
    property p_wr_quiet; wr_act |=> !data_oe; endproperty
    property p_ctl_hidden; s_ctl_rd |=> data_out == 8'h00; endproperty
    property p_out_zero; !data_oe |-> data_out == 8'h00; endproperty
    property p_rst_in; $fell(rst) |-> !data_oe && first_port_lines_oe == 8'h00
        && second_port_lines_oe == 8'h00 && third_port_lines_oe == 8'h00; endproperty
    // Direction of the second port moves only as a write takes effect
    property p_oe_cause; $changed(second_port_lines_oe) |-> $past(wr_act, 3); endproperty
    property p_ibf; s_stb |-> ##[1:3] third_port_lines_out[5]; endproperty
    property p_whole; first_port_lines_oe == 8'h00 || first_port_lines_oe == 8'hFF; endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("bus not driven after read");
    a_float: assert property (p_float) else $error("bus driven while idle");
    a_wr_quiet: assert property (p_wr_quiet) else $error("bus driven during write");
    a_ctl_hidden: assert property (p_ctl_hidden) else $error("control word visible");
    a_out_zero: assert property (p_out_zero) else $error("bus value while floating");
    a_rst_in: assert property (p_rst_in) else $error("port drives after reset");
    a_oe_cause: assert property (p_oe_cause) else $error("direction changed without write");
    a_ibf: assert property (p_ibf) else $error("input full flag missing");
    a_whole: assert property (p_whole) else $error("first port split direction");
endmodule // ppio_sva
bind ppio_top ppio_sva ppio_sva_i (.mclk, .rst, .cs_n, .rd_n, .wr_n, .register_select_lines, .data_out, .data_oe,
    .first_port_lines_oe, .second_port_lines_oe, .third_port_lines_in, .third_port_lines_out, .third_port_lines_oe);
